// ---- hdl/pac_defs.vh ----
`ifndef PAC_DEFS_VH
`define PAC_DEFS_VH

// Register addresses on the plain port
`define PAC_ADDR_W          4
`define PAC_ADDR_CONTROL    4'h6
`define PAC_ADDR_COUNT      4'h7
`define PAC_ADDR_MASK_TWO   4'h4
`define PAC_ADDR_FLAGS_TWO  4'h5

// Control register fields
`define PAC_CTL_PORT_A7_DIR 7
`define PAC_CTL_SYS_EN      6
`define PAC_CTL_MODE        5
`define PAC_CTL_EDGE        4
`define PAC_CTL_PORT_A3_DIR 3
`define PAC_CTL_CHAN_SEL    2
`define PAC_CTL_RATE_HI     1
`define PAC_CTL_RATE_LO     0
`define PAC_CTL_RESET       8'h00

// Flag and mask fields
`define PAC_FLG_OVF         5
`define PAC_FLG_EDGE        4
`define PAC_MASK_RESET      2'h0

// E clock and tick timing
`define PAC_E_DIV           4
`define PAC_TICK_DIV        64

`endif

// ---- hdl/pac_sync.v ----
`timescale 1ns/1ps
module pac_sync
(
  input  wire ref_clk,
  input  wire nrst,
  input  wire din,
  output wire dout
);

  reg stage_one;
  reg stage_two;

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage_one <= 1'b0;
      stage_two <= 1'b0;
    end
    else
    begin
      stage_one <= din;
      stage_two <= stage_one;
    end
  end

  assign dout = stage_two;

endmodule

// ---- hdl/pac_tick.v ----
`timescale 1ns/1ps
`include "pac_defs.vh"
module pac_tick
#(
  parameter E_DIV    = `PAC_E_DIV,
  parameter TICK_DIV = `PAC_TICK_DIV
)
(
  input  wire ref_clk,
  input  wire nrst,
  output reg  e_phase,
  output reg  tick
);

  reg [7:0] e_cnt;
  reg [5:0] t_cnt;

  // Free-running E phase and divide-by-64 tick
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      e_cnt   <= 8'h00;
      t_cnt   <= 6'h00;
      e_phase <= 1'b0;
      tick    <= 1'b0;
    end
    else
    begin
      e_phase <= 1'b0;
      tick    <= 1'b0;
      if (e_cnt == E_DIV[7:0] - 8'h01)
      begin
        e_cnt   <= 8'h00;
        e_phase <= 1'b1;
        if (t_cnt == TICK_DIV[5:0] - 6'h01)
        begin
          t_cnt <= 6'h00;
          tick  <= 1'b1;
        end
        else
          t_cnt <= t_cnt + 6'h01;
      end
      else
        e_cnt <= e_cnt + 8'h01;
    end
  end

endmodule

// ---- hdl/pac_top.v ----
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "pac_defs.vh"
module pac_top
#(
  parameter E_DIV    = `PAC_E_DIV,
  parameter TICK_DIV = `PAC_TICK_DIV
)
(
  input  wire       ref_clk,
  input  wire       nrst,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_stb,
  input  wire       rd_stb,
  output reg  [7:0] rdata,
  input  wire       accum_input_pin,
  output reg        accum_overflow_irq,
  output reg        accum_edge_irq,
  output reg        input_capture_four,
  output reg        output_compare_five,
  output reg        port_a7_direction,
  output reg        port_a3_direction,
  output reg  [1:0] periodic_rate_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [7:0] accumulator_control;
  reg  [7:0] accumulator_count;
  reg        accum_overflow_irq_en;
  reg        accum_edge_irq_en;
  reg        accum_overflow_flag;
  reg        accum_edge_flag;
  reg        pin_prev;
  reg        inc_pending;
  wire       pin_sync;
  wire       e_phase;
  wire       tick;

  wire accum_system_enable = accumulator_control[`PAC_CTL_SYS_EN];
  wire accum_mode_sel      = accumulator_control[`PAC_CTL_MODE];
  wire accum_edge_ctrl     = accumulator_control[`PAC_CTL_EDGE];

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser and timebase

  pac_sync u_sync
  (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     (accum_input_pin),
    .dout    (pin_sync)
  );

  pac_tick #(.E_DIV(E_DIV), .TICK_DIV(TICK_DIV)) u_tick
  (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .e_phase (e_phase),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge and gate detection

  wire rise      = pin_sync & ~pin_prev;
  wire fall      = ~pin_sync & pin_prev;
  wire sel_edge  = accum_edge_ctrl ? rise : fall;
  wire gate_open = accum_edge_ctrl ? ~pin_sync : pin_sync;
  wire wr_count  = wr_stb && (addr == `PAC_ADDR_COUNT);
  wire wr_flags  = wr_stb && (addr == `PAC_ADDR_FLAGS_TWO);
  wire count_evt = accum_system_enable &&
                   (accum_mode_sel ? (tick && gate_open) : sel_edge);
  wire do_inc    = inc_pending && !e_phase;
  wire wrap      = do_inc && !wr_count && (accumulator_count == 8'hff);

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      pin_prev <= 1'b0;
    else
      pin_prev <= pin_sync;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, not reset

  always @(posedge ref_clk)
  begin
    if (wr_count)
      accumulator_count <= wdata;
    else if (do_inc)
      accumulator_count <= accumulator_count + 8'h01;
  end

  // Increment waits off the read phase
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      inc_pending <= 1'b0;
    else if (count_evt)
      inc_pending <= 1'b1;
    else if (do_inc)
      inc_pending <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, mask and flags

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      accumulator_control   <= `PAC_CTL_RESET;
      accum_overflow_irq_en <= 1'b0;
      accum_edge_irq_en     <= 1'b0;
    end
    else if (wr_stb)
    begin
      if (addr == `PAC_ADDR_CONTROL)
        accumulator_control <= wdata;
      if (addr == `PAC_ADDR_MASK_TWO)
      begin
        accum_overflow_irq_en <= wdata[`PAC_FLG_OVF];
        accum_edge_irq_en     <= wdata[`PAC_FLG_EDGE];
      end
    end
  end

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      accum_overflow_flag <= 1'b0;
      accum_edge_flag     <= 1'b0;
    end
    else
    begin
      if (wrap)
        accum_overflow_flag <= 1'b1;
      else if (wr_flags && wdata[`PAC_FLG_OVF])
        accum_overflow_flag <= 1'b0;
      if (accum_system_enable && sel_edge)
        accum_edge_flag <= 1'b1;
      else if (wr_flags && wdata[`PAC_FLG_EDGE])
        accum_edge_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      accum_overflow_irq  <= 1'b0;
      accum_edge_irq      <= 1'b0;
      input_capture_four  <= 1'b0;
      output_compare_five <= 1'b0;
      port_a7_direction   <= 1'b0;
      port_a3_direction   <= 1'b0;
      periodic_rate_sel   <= 2'h0;
    end
    else
    begin
      accum_overflow_irq  <= accum_overflow_flag & accum_overflow_irq_en;
      accum_edge_irq      <= accum_edge_flag & accum_edge_irq_en;
      input_capture_four  <= accumulator_control[`PAC_CTL_CHAN_SEL];
      output_compare_five <= ~accumulator_control[`PAC_CTL_CHAN_SEL];
      port_a7_direction   <= accumulator_control[`PAC_CTL_PORT_A7_DIR];
      port_a3_direction   <= accumulator_control[`PAC_CTL_PORT_A3_DIR];
      periodic_rate_sel   <= accumulator_control[`PAC_CTL_RATE_HI:`PAC_CTL_RATE_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else if (rd_stb)
    begin
      case (addr)
        `PAC_ADDR_CONTROL:   rdata <= accumulator_control;
        `PAC_ADDR_COUNT:     rdata <= accumulator_count;
        `PAC_ADDR_MASK_TWO:  rdata <= {2'h0, accum_overflow_irq_en, accum_edge_irq_en, 4'h0};
        `PAC_ADDR_FLAGS_TWO: rdata <= {2'h0, accum_overflow_flag, accum_edge_flag, 4'h0};
        default:             rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

endmodule

// ---- test/pac_monitor.sv ----
`timescale 1ns/1ps
`include "pac_defs.vh"
module pac_monitor
#(
  parameter E_DIV    = 4,
  parameter TICK_DIV = 64
)
(
  input wire       ref_clk,
  input wire       nrst,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire       wr_stb,
  input wire       rd_stb,
  input wire [7:0] rdata,
  input wire       accum_input_pin,
  input wire       accum_overflow_irq,
  input wire       accum_edge_irq,
  input wire       input_capture_four,
  input wire       output_compare_five,
  input wire       port_a7_direction,
  input wire       port_a3_direction,
  input wire [1:0] periodic_rate_sel
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  reg  [7:0] ctl;
  wire       wc = wr_stb && addr == `PAC_ADDR_CONTROL;
  wire       wf = wr_stb && addr == `PAC_ADDR_FLAGS_TWO;
  always @(posedge ref_clk)
    if (wc)
      ctl <= wdata;
  a_sel_follow: assert property (wc |-> ##2 {input_capture_four, output_compare_five} ==
    {ctl[2], !ctl[2]}) else $error("channel select outputs wrong");
  a_ctl_outputs: assert property (wc |-> ##2 {port_a7_direction, port_a3_direction,
    periodic_rate_sel} == {ctl[7], ctl[3], ctl[1:0]}) else $error("control outputs wrong");
  a_ctl_readback: assert property (rd_stb && addr == `PAC_ADDR_CONTROL |=> rdata[3:0] ==
    {port_a3_direction, input_capture_four, periodic_rate_sel}) else $error("control read");
  a_mask_bits: assert property (rd_stb && addr == `PAC_ADDR_MASK_TWO |=>
    {rdata[7:6], rdata[3:0]} == 6'h00) else $error("mask unused bits set");
  a_flag_bits: assert property (rd_stb && addr == `PAC_ADDR_FLAGS_TWO |=>
    {rdata[7:6], rdata[3:0]} == 6'h00) else $error("flag unused bits set");
  a_ovf_clear: assert property (wf && wdata[5] |-> ##2 !accum_overflow_irq)
    else $error("overflow not cleared");
  a_edge_clear: assert property (wf && wdata[4] |-> ##2 !accum_edge_irq)
    else $error("edge not cleared");
  a_ovf_hold: assert property (accum_overflow_irq && !wr_stb && !$past(wr_stb) |=>
    accum_overflow_irq) else $error("overflow request dropped");
  a_edge_hold: assert property (accum_edge_irq && !wr_stb && !$past(wr_stb) |=>
    accum_edge_irq) else $error("edge request dropped");
endmodule
bind pac_top pac_monitor #(.E_DIV(E_DIV), .TICK_DIV(TICK_DIV)) i_pac_monitor (
  .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .accum_input_pin(accum_input_pin),
  .accum_overflow_irq(accum_overflow_irq), .accum_edge_irq(accum_edge_irq),
  .input_capture_four(input_capture_four), .output_compare_five(output_compare_five),
  .port_a7_direction(port_a7_direction), .port_a3_direction(port_a3_direction),
  .periodic_rate_sel(periodic_rate_sel));

// ---- test/pac_pin_model.sv ----
`timescale 1ns/1ps
module pac_pin_model
(
  input  logic ref_clk,
  output logic pin
);
  initial pin = 1'b0;
  // Each level is held at least two E periods
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge ref_clk) pin <= 1'b1;
      repeat (8) @(posedge ref_clk);
      pin <= 1'b0;
      repeat (8) @(posedge ref_clk);
    end
  endtask
  task automatic level(input logic v);
    @(posedge ref_clk) pin <= v;
    repeat (12) @(posedge ref_clk);
  endtask
endmodule

// ---- test/tb_pac_top.sv ----
`timescale 1ns/1ps
`include "pac_defs.vh"
module tb_pac_top;
  localparam TP = 16;
  logic       ref_clk;
  logic       nrst;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr_stb;
  logic       rd_stb;
  wire  [7:0] rdata;
  wire        pin;
  wire        ovf;
  wire        edg;
  wire        ic4;
  wire        oc5;
  wire        a7;
  wire        a3;
  wire  [1:0] rate;
  int         n_fail;
  int         tests_run;
  pac_top #(.E_DIV(4), .TICK_DIV(4)) i_pac_top (.ref_clk(ref_clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .accum_input_pin(pin), .accum_overflow_irq(ovf), .accum_edge_irq(edg),
    .input_capture_four(ic4), .output_compare_five(oc5), .port_a7_direction(a7),
    .port_a3_direction(a3), .periodic_rate_sel(rate));
  pac_pin_model i_pac_pin_model (.ref_clk(ref_clk), .pin(pin));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge ref_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, exp, nm);
  endtask
  task automatic summarize;
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #100000;
    n_fail++;
    summarize();
  end
  initial
  begin
    n_fail = 0;
    tests_run = 0;
    nrst = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(`PAC_ADDR_CONTROL, 8'h00, "ctl_rst");
    rd(`PAC_ADDR_MASK_TWO, 8'h00, "mask_rst");
    rd(4'h0, 8'h00, "unmapped");
    wr(`PAC_ADDR_CONTROL, 8'h8f);
    rd(`PAC_ADDR_CONTROL, 8'h8f, "ctl_rw");
    chk({a7, a3, ic4, oc5, 2'b00, rate}, 8'he3, "ctl_pins");
    wr(`PAC_ADDR_CONTROL, 8'h00);
    wr(`PAC_ADDR_COUNT, 8'h5a);
    i_pac_pin_model.pulses(3);
    rd(`PAC_ADDR_COUNT, 8'h5a, "cnt_off");
    rd(`PAC_ADDR_FLAGS_TWO, 8'h00, "flag_off");
    @(posedge ref_clk) nrst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(`PAC_ADDR_COUNT, 8'h5a, "cnt_rst");
    wr(`PAC_ADDR_MASK_TWO, 8'h30);
    wr(`PAC_ADDR_CONTROL, 8'h40);
    wr(`PAC_ADDR_COUNT, 8'hfe);
    i_pac_pin_model.level(1'b1);
    rd(`PAC_ADDR_COUNT, 8'hfe, "fall_rise");
    i_pac_pin_model.pulses(3);
    repeat (10) @(posedge ref_clk);
    rd(`PAC_ADDR_COUNT, 8'h01, "fall_cnt");
    rd(`PAC_ADDR_FLAGS_TWO, 8'h30, "flags");
    chk({6'h00, ovf, edg}, 8'h03, "irqs_on");
    wr(`PAC_ADDR_MASK_TWO, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk({6'h00, ovf, edg}, 8'h00, "irqs_off");
    rd(`PAC_ADDR_FLAGS_TWO, 8'h30, "flags_kept");
    wr(`PAC_ADDR_MASK_TWO, 8'h30);
    wr(`PAC_ADDR_FLAGS_TWO, 8'h20);
    rd(`PAC_ADDR_FLAGS_TWO, 8'h10, "ovf_clr");
    wr(`PAC_ADDR_FLAGS_TWO, 8'h10);
    rd(`PAC_ADDR_FLAGS_TWO, 8'h00, "edge_clr");
    wr(`PAC_ADDR_CONTROL, 8'h50);
    wr(`PAC_ADDR_COUNT, 8'h10);
    i_pac_pin_model.level(1'b1);
    rd(`PAC_ADDR_COUNT, 8'h11, "rise_cnt");
    rd(`PAC_ADDR_FLAGS_TWO, 8'h10, "edge_set");
    i_pac_pin_model.level(1'b0);
    rd(`PAC_ADDR_COUNT, 8'h11, "rise_fall");
    wr(`PAC_ADDR_CONTROL, 8'h60);
    wr(`PAC_ADDR_COUNT, 8'h00);
    repeat (5 * TP) @(posedge ref_clk);
    rd(`PAC_ADDR_COUNT, 8'h00, "gate_low");
    @(posedge ref_clk);
    i_pac_pin_model.level(1'b1);
    repeat (8 * TP - 13) @(posedge ref_clk);
    i_pac_pin_model.level(1'b0);
    rd(`PAC_ADDR_COUNT, 8'h08, "gate_cnt");
    i_pac_pin_model.level(1'b1);
    wr(`PAC_ADDR_CONTROL, 8'h70);
    wr(`PAC_ADDR_COUNT, 8'h00);
    repeat (5 * TP) @(posedge ref_clk);
    rd(`PAC_ADDR_COUNT, 8'h00, "gate_high");
    summarize();
  end
endmodule
